// >>> logic/tvc_pkg.sv
// Constants, register map and types of the thermostat valve controller
package tvc_pkg;

  // ==========================================================
  // Timebase
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned TICK_S       = 1;
  localparam int unsigned TICK_CYCLES  = CLK_HZ * TICK_S;
  localparam int unsigned SEC_PER_MIN  = 60;
  localparam int unsigned LOCKOUT_MIN  = 2;
  // One extra tick: the first tick after the load may come at once
  localparam logic [7:0]  LOCKOUT_TICKS = 8'(LOCKOUT_MIN * SEC_PER_MIN / TICK_S + 1);

  // ==========================================================
  // Register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  localparam logic [3:0] OFS_CTRL       = 4'h0;
  localparam logic [3:0] OFS_SETPOINT   = 4'h1;
  localparam logic [3:0] OFS_HEAT_DIFF  = 4'h2;
  localparam logic [3:0] OFS_COOL_DIFF  = 4'h3;
  localparam logic [3:0] OFS_PBAND      = 4'h4;
  localparam logic [3:0] OFS_INTEG_TIME = 4'h5;
  localparam logic [3:0] OFS_CYCLE_TIME = 4'h6;
  localparam logic [3:0] OFS_STATUS     = 4'h8;
  localparam logic [3:0] OFS_DUTY       = 4'h9;
  localparam logic [3:0] OFS_TEMP       = 4'ha;

  // Control register fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_COOL_BIT = 1;
  localparam int CTRL_ALG_LSB = 2;
  localparam int ALG_W        = 3;

  // Status register fields
  localparam int STAT_HEAT_BIT = 0;
  localparam int STAT_COOL_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;

  // ==========================================================
  // Values after reset (temperatures in tenths of a degree)
  localparam logic [15:0] RST_SETPOINT   = 16'h00c8;
  localparam logic [15:0] RST_HEAT_DIFF  = 16'h0002;
  localparam logic [15:0] RST_COOL_DIFF  = 16'h0002;
  localparam logic [15:0] RST_PBAND      = 16'h0014;
  localparam logic [7:0]  RST_INTEG_TIME = 8'h3c;
  localparam logic [7:0]  RST_CYCLE_TIME = 8'h0a;

  localparam logic [6:0]  PCT_FULL   = 7'h64;
  localparam logic [31:0] PCT_FULL32 = 32'h0000_0064;
  localparam int          INTEG_LIM_DEF = 32'h0001_0000;

  // ==========================================================
  // Types
  typedef enum logic [2:0]
  {
    TVC_ALG_ONOFF   = 3'h0,
    TVC_ALG_PCT     = 3'h1,
    TVC_ALG_PWM     = 3'h2,
    TVC_ALG_CONT    = 3'h3,
    TVC_ALG_FANCOIL = 3'h4
  } tvc_alg_t;

  typedef enum logic [1:0]
  {
    TVC_ST_OFF  = 2'b00,
    TVC_ST_ON   = 2'b01,
    TVC_ST_LOCK = 2'b11
  } tvc_st_t;

endpackage

// >>> logic/tvc_tick.sv
// Divider that issues a one-cycle tick every DIV clocks
`timescale 1ns/1ps
module tvc_tick
#(
  parameter int unsigned DIV = 10
)
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // Phase control and tick
  input  wire logic clr,
  output logic      tick_reg
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt_reg;

  // Count DIV cycles; clr restarts the phase so a new period is whole
  always_ff @(posedge core_clk)
  begin
    if (srst || clr)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else if (cnt_reg == CW'(DIV - 1))
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b1;
    end
    else
    begin
      cnt_reg  <= cnt_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

endmodule

// >>> logic/tvc_core.sv
// Thermostat valve controller: two-point and PWM PI valve commands
// Notes on behaviour
// - Heating: valve on below setpoint minus differential
// - Heating: valve off when setpoint reached
// - Cooling: valve on above setpoint plus differential
// - Cooling: valve off when back at setpoint
// - On/off: after off-on-off, wait two minutes
// - Percentage mode sends 100 or 0 percent
// - Percentage: after 0-100-0, wait two minutes
// - PWM output is proportional plus integral term
// - Proportional term is gain times setpoint error
// - Duty linear in band, saturates outside
// - Integral accumulates error, scaled by integral gain
// - PWM heating: on fraction per cycle time
// - PWM cooling: on fraction per cycle time
// - Setpoint change restarts PWM cycle period
// - Integral gain derived from integration time
// - One algorithm selection governs heating and cooling
`timescale 1ns/1ps
module tvc_core
  import tvc_pkg::*;
#(
  parameter int unsigned TICK_DIV  = tvc_pkg::TICK_CYCLES,
  parameter int          INTEG_LIM = tvc_pkg::INTEG_LIM_DEF
)
(
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  // Register port
  input  wire logic [tvc_pkg::ADDR_W-1:0] addr,
  input  wire logic [tvc_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic [tvc_pkg::DATA_W-1:0]      rd_data_reg,
  // Measured temperature, tenths of a degree, signed
  input  wire logic [15:0]                temp_meas,
  // Valve commands towards the actuator telegram sender
  output logic                            heat_valve_reg,
  output logic                            cool_valve_reg,
  output logic [6:0]                      valve_pct_reg,
  output logic                            cmd_send_reg
);

  // ==========================================================
  // Declarations
  logic        ctrl_en_reg;
  logic        ctrl_cool_reg;
  tvc_alg_t    ctrl_alg_reg;
  logic [15:0] setpoint_reg;
  logic [15:0] heat_regulation_differential_reg;
  logic [15:0] cool_regulation_differential_reg;
  logic [15:0] pband_reg;
  logic [7:0]  integ_time_reg;
  logic [7:0]  cycle_time_reg;

  tvc_st_t     st_reg;
  logic [7:0]  lock_cnt_reg;

  logic        pwm_start_reg;
  logic [15:0] pwm_sec_reg;
  logic [15:0] on_s_reg;
  logic [6:0]  duty_reg;
  logic signed [31:0] integ_reg;

  logic        sec_tick;
  logic        tp_active;
  logic        pwm_active;
  logic        sp_chg;
  logic        restart;
  logic signed [17:0] meas_s;
  logic signed [17:0] sp_s;
  logic signed [17:0] err;
  logic        want_on;
  logic        want_off;
  logic [7:0]  cyc_min_eff;
  logic [15:0] cycle_s;
  logic [15:0] band_eff;

  logic signed [31:0] integ_sum;
  logic signed [31:0] proportional_term;
  logic signed [31:0] integral_term;
  logic signed [31:0] pi_out;
  logic [6:0]  duty_next;
  logic [15:0] on_s_next;

  logic        pwm_demand;
  logic        cmd_on;
  logic        heat_next;
  logic        cool_next;

  // ==========================================================
  // Seconds timebase; runs free for the lockout, realigned at PWM start
  tvc_tick
  #(
    .DIV      (TICK_DIV)
  )
  u_sec_tick
  (
    .core_clk (core_clk),
    .srst     (srst),
    .clr      (pwm_start_reg && pwm_active),
    .tick_reg (sec_tick)
  );

  // ==========================================================
  // Register writes
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ctrl_en_reg                      <= 1'b0;
      ctrl_cool_reg                    <= 1'b0;
      ctrl_alg_reg                     <= TVC_ALG_ONOFF;
      setpoint_reg                     <= RST_SETPOINT;
      heat_regulation_differential_reg <= RST_HEAT_DIFF;
      cool_regulation_differential_reg <= RST_COOL_DIFF;
      pband_reg                        <= RST_PBAND;
      integ_time_reg                   <= RST_INTEG_TIME;
      cycle_time_reg                   <= RST_CYCLE_TIME;
    end
    else if (wr_en)
    begin
      if (addr == OFS_CTRL)
      begin
        ctrl_en_reg   <= wr_data[CTRL_EN_BIT];
        ctrl_cool_reg <= wr_data[CTRL_COOL_BIT];
        ctrl_alg_reg  <= tvc_alg_t'(wr_data[CTRL_ALG_LSB +: ALG_W]);
      end
      else if (addr == OFS_SETPOINT)
        setpoint_reg <= wr_data;
      else if (addr == OFS_HEAT_DIFF)
        heat_regulation_differential_reg <= wr_data;
      else if (addr == OFS_COOL_DIFF)
        cool_regulation_differential_reg <= wr_data;
      else if (addr == OFS_PBAND)
        pband_reg <= wr_data;
      else if (addr == OFS_INTEG_TIME)
        integ_time_reg <= wr_data[7:0];
      else if (addr == OFS_CYCLE_TIME)
        cycle_time_reg <= wr_data[7:0];
    end
  end

  // ==========================================================
  // Register reads: data in the cycle after the strobe only
  always_ff @(posedge core_clk)
  begin
    if (srst || !rd_en)
      rd_data_reg <= '0;
    else if (addr == OFS_CTRL)
      rd_data_reg <= 16'({ctrl_alg_reg, ctrl_cool_reg, ctrl_en_reg});
    else if (addr == OFS_SETPOINT)
      rd_data_reg <= setpoint_reg;
    else if (addr == OFS_HEAT_DIFF)
      rd_data_reg <= heat_regulation_differential_reg;
    else if (addr == OFS_COOL_DIFF)
      rd_data_reg <= cool_regulation_differential_reg;
    else if (addr == OFS_PBAND)
      rd_data_reg <= pband_reg;
    else if (addr == OFS_INTEG_TIME)
      rd_data_reg <= 16'(integ_time_reg);
    else if (addr == OFS_CYCLE_TIME)
      rd_data_reg <= 16'(cycle_time_reg);
    else if (addr == OFS_STATUS)
      rd_data_reg <= 16'({(st_reg == TVC_ST_LOCK), cool_valve_reg, heat_valve_reg});
    else if (addr == OFS_DUTY)
      rd_data_reg <= 16'(duty_reg);
    else if (addr == OFS_TEMP)
      rd_data_reg <= temp_meas;
    else
      rd_data_reg <= '0;   // Unmapped reads return zero
  end

  // ==========================================================
  // Mode decode and restart events
  // one selection for both directions
  assign tp_active  = ctrl_en_reg &&
                      ((ctrl_alg_reg == TVC_ALG_ONOFF) || (ctrl_alg_reg == TVC_ALG_PCT));
  assign pwm_active = ctrl_en_reg && (ctrl_alg_reg == TVC_ALG_PWM);

  assign sp_chg  = wr_en && (addr == OFS_SETPOINT) && (wr_data != setpoint_reg);
  // A new cycle time or mode also starts a fresh period
  assign restart = sp_chg ||
                   (wr_en && ((addr == OFS_CTRL) || (addr == OFS_CYCLE_TIME)));

  // ==========================================================
  // Error and hysteresis thresholds, 18-bit signed to avoid overflow
  assign meas_s = 18'(signed'(temp_meas));
  assign sp_s   = 18'(signed'(setpoint_reg));
  assign err    = ctrl_cool_reg ? (meas_s - sp_s) : (sp_s - meas_s);

  always_comb
  begin
    want_on  = 1'b0;
    want_off = 1'b0;
    if (ctrl_cool_reg)
    begin
      want_on  = meas_s > (sp_s + signed'({2'b00, cool_regulation_differential_reg}));
      want_off = meas_s <= sp_s;
    end
    else
    begin
      want_on  = meas_s < (sp_s - signed'({2'b00, heat_regulation_differential_reg}));
      want_off = meas_s >= sp_s;
    end
  end

  // ==========================================================
  // Two-point state machine; LOCK holds the valve off after on-off
  always_ff @(posedge core_clk)
  begin
    if (srst)
      st_reg <= TVC_ST_OFF;
    else
    begin
      case (st_reg)
        TVC_ST_OFF:
          if (tp_active && want_on)
            st_reg <= TVC_ST_ON;
        TVC_ST_ON:
          // Leaving the algorithm also counts as an off command
          if (!tp_active || want_off)
            st_reg <= TVC_ST_LOCK;
        TVC_ST_LOCK:
          if (lock_cnt_reg == 8'h00)
            st_reg <= TVC_ST_OFF;
        default:
          st_reg <= TVC_ST_OFF;
      endcase
    end
  end

  // Lockout timer in seconds, loaded at each on-to-off change
  always_ff @(posedge core_clk)
  begin
    if (srst)
      lock_cnt_reg <= 8'h00;
    else if ((st_reg == TVC_ST_ON) && (!tp_active || want_off))
      lock_cnt_reg <= LOCKOUT_TICKS;
    else if (sec_tick && (lock_cnt_reg != 8'h00))
      lock_cnt_reg <= lock_cnt_reg - 8'h01;
  end

  // ==========================================================
  // PI computation, evaluated only at PWM period start.
  // Plain dividers keep this simple; the rate is one per period,
  // so their depth only costs area, not throughput.
  assign cyc_min_eff = (cycle_time_reg == 8'h00) ? 8'h01 : cycle_time_reg;
  assign cycle_s     = 16'(cyc_min_eff) * 16'(SEC_PER_MIN);
  assign band_eff    = (pband_reg == 16'h0000) ? 16'h0001 : pband_reg;

  always_comb
  begin
    integ_sum = integ_reg + 32'(err) * signed'(32'(cyc_min_eff));
    if (integ_time_reg == 8'h00)
      integ_sum = '0;   // Zero integration time disables the integral
    else if (integ_sum > INTEG_LIM)
      integ_sum = INTEG_LIM;   // Anti-windup
    else if (integ_sum < -INTEG_LIM)
      integ_sum = -INTEG_LIM;

    // proportional gain is 100 percent per band
    proportional_term = (32'(err) * signed'(PCT_FULL32)) / signed'(32'(band_eff));

    // integral gain is proportional gain over time
    if (integ_time_reg == 8'h00)
      integral_term = '0;
    else
      integral_term = (integ_sum * signed'(PCT_FULL32)) /
                      signed'(32'(band_eff) * 32'(integ_time_reg));

    // output is sum of both terms
    pi_out = proportional_term + integral_term;

    // clamp to 0 .. 100 percent
    if (pi_out < 0)
      duty_next = 7'h00;
    else if (pi_out > signed'(PCT_FULL32))
      duty_next = PCT_FULL;
    else
      duty_next = pi_out[6:0];

    // Seconds of on time within the period
    on_s_next = 16'((32'(duty_next) * 32'(cycle_s)) / PCT_FULL32);
  end

  // ==========================================================
  // PWM period counter in seconds
  always_ff @(posedge core_clk)
  begin
    if (srst || !pwm_active || restart)
    begin
      pwm_start_reg <= 1'b1;
      pwm_sec_reg   <= 16'h0000;
    end
    else if (pwm_start_reg)
    begin
      pwm_start_reg <= 1'b0;
      pwm_sec_reg   <= 16'h0000;
    end
    else if (sec_tick)
    begin
      if (pwm_sec_reg >= (cycle_s - 16'h0001))
        pwm_start_reg <= 1'b1;
      else
        pwm_sec_reg <= pwm_sec_reg + 16'h0001;
    end
  end

  // Output recomputed once per period
  always_ff @(posedge core_clk)
  begin
    if (srst || !pwm_active)
    begin
      integ_reg <= '0;
      duty_reg  <= 7'h00;
      on_s_reg  <= 16'h0000;
    end
    else if (pwm_start_reg)
    begin
      integ_reg <= integ_sum;
      duty_reg  <= duty_next;
      on_s_reg  <= on_s_next;
    end
  end

  assign pwm_demand = pwm_start_reg ? (on_s_next != 16'h0000) : (pwm_sec_reg < on_s_reg);

  // ==========================================================
  // Valve command and telegram strobe
  assign cmd_on    = ((st_reg == TVC_ST_ON) && tp_active) || (pwm_active && pwm_demand);
  assign heat_next = cmd_on && !ctrl_cool_reg;
  assign cool_next = cmd_on && ctrl_cool_reg;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      heat_valve_reg <= 1'b0;
      cool_valve_reg <= 1'b0;
      valve_pct_reg  <= 7'h00;
      cmd_send_reg   <= 1'b0;
    end
    else
    begin
      heat_valve_reg <= heat_next;
      cool_valve_reg <= cool_next;
      valve_pct_reg  <= cmd_on ? PCT_FULL : 7'h00;
      cmd_send_reg   <= (heat_next != heat_valve_reg) || (cool_next != cool_valve_reg);
    end
  end

endmodule

// >>> verification/tvc_core_chk.sv
// Port-level assertions for the thermostat valve controller
`timescale 1ns/1ps
module tvc_core_chk
  import tvc_pkg::*;
#(
  parameter int unsigned TICK_DIV  = 10,
  parameter int          INTEG_LIM = 1
)
(
  // Clock, reset and register port
  input wire logic                       core_clk,
  input wire logic                       srst,
  input wire logic [tvc_pkg::ADDR_W-1:0] addr,
  input wire logic [tvc_pkg::DATA_W-1:0] wr_data,
  input wire logic                       wr_en,
  input wire logic                       rd_en,
  input wire logic [tvc_pkg::DATA_W-1:0] rd_data_reg,
  // Temperature and valve commands
  input wire logic [15:0]                temp_meas,
  input wire logic                       heat_valve_reg,
  input wire logic                       cool_valve_reg,
  input wire logic [6:0]                 valve_pct_reg,
  input wire logic                       cmd_send_reg
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  // ========
  // Shadow of the control, setpoint and heating differential registers, updated exactly as a bus write lands
  logic [15:0] ctrl_sh;
  logic [15:0] sp_sh;
  logic [15:0] hd_sh;
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ctrl_sh <= 16'h0000;
      sp_sh   <= RST_SETPOINT;
      hd_sh   <= RST_HEAT_DIFF;
    end
    else if (wr_en)
    begin
      if (addr == OFS_CTRL)
        ctrl_sh <= wr_data;
      if (addr == OFS_SETPOINT)
        sp_sh <= wr_data;
      if (addr == OFS_HEAT_DIFF)
        hd_sh <= wr_data;
    end
  end

  // Two-point decisions only; PWM timing is left to the bench
  logic two_pt;
  logic heat_md;
  logic cool_md;
  logic heat_lo;
  logic at_sp;
  logic cool_dn;
  assign two_pt  = ctrl_sh[CTRL_EN_BIT] && (ctrl_sh[4:2] < 3'h2);
  assign heat_md = two_pt && !ctrl_sh[CTRL_COOL_BIT];
  assign cool_md = two_pt && ctrl_sh[CTRL_COOL_BIT];
  assign heat_lo = $signed(temp_meas) < $signed(sp_sh - hd_sh);
  assign at_sp   = $signed(temp_meas) >= $signed(sp_sh);
  assign cool_dn = $signed(temp_meas) <= $signed(sp_sh);

  // ========
  // Assertions
  heat_on_a: assert property (
    $rose(heat_valve_reg) && $past(heat_md) && !$past(cool_valve_reg) |-> $past(heat_lo, 2))
    else $error("heat valve opened above threshold");
  heat_off_a: assert property (
    heat_md && heat_valve_reg && at_sp |-> ##2 !heat_valve_reg)
    else $error("heat valve stayed on at setpoint");
  cool_off_a: assert property (
    cool_md && cool_valve_reg && cool_dn |-> ##2 !cool_valve_reg)
    else $error("cool valve stayed on at setpoint");
  pct_match_a: assert property (
    valve_pct_reg == ((heat_valve_reg || cool_valve_reg) ? PCT_FULL : 7'h00))
    else $error("percent command disagrees with valve state");
  send_once_a: assert property (
    cmd_send_reg |=> !cmd_send_reg)
    else $error("send pulse longer than one cycle");
  send_cause_a: assert property (
    cmd_send_reg |-> $changed(heat_valve_reg) || $changed(cool_valve_reg))
    else $error("telegram without valve change");
  change_send_a: assert property (
    $changed(heat_valve_reg) || $changed(cool_valve_reg) |-> cmd_send_reg)
    else $error("valve change without telegram");
  valve_excl_a: assert property (
    !(heat_valve_reg && cool_valve_reg))
    else $error("both valves commanded on");
  rd_idle_a: assert property (
    !rd_en |=> rd_data_reg == 16'h0000)
    else $error("read data not zero outside a read");
  rd_temp_a: assert property (
    rd_en && addr == OFS_TEMP |=> rd_data_reg == $past(temp_meas))
    else $error("temperature read mismatch");
endmodule

// >>> verification/tvc_actuator.sv
// Model of the bus actuator that receives the valve command telegrams
`timescale 1ns/1ps
module tvc_actuator
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // Telegram from the controller
  input  wire logic send,
  input  wire logic heat_cmd,
  input  wire logic cool_cmd,
  // Telegram count and valve positions
  output int        telegrams,
  output logic      heat_open,
  output logic      cool_open
);
  // Valves move only when a telegram arrives, so a lost pulse shows up here
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      telegrams <= 0;
      heat_open <= 1'b0;
      cool_open <= 1'b0;
    end
    else if (send)
    begin
      telegrams <= telegrams + 1;
      heat_open <= heat_cmd;
      cool_open <= cool_cmd;
    end
  end
endmodule

// >>> verification/tb.sv
// Directed bench for the thermostat valve controller
`timescale 1ns/1ps
module tb;
  import tvc_pkg::*;
  localparam int unsigned TD = 10;

  // ========
  // Design ports and bench state
  logic        core_clk;
  logic        srst;
  logic [3:0]  addr;
  logic [15:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] temp_meas;
  logic [15:0] rd_data_reg;
  logic        heat_valve_reg;
  logic        cool_valve_reg;
  logic [6:0]  valve_pct_reg;
  logic        cmd_send_reg;
  logic        act_heat;
  logic        act_cool;
  int          telegrams;
  int          fails = 0;
  int          check_count = 0;
  // Index and value after reset; 7 and f are unmapped
  logic [3:0]  ra [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'ha, 4'hf};
  logic [15:0] rv [10] = '{16'h0000, 16'h00c8, 16'h0002, 16'h0002, 16'h0014, 16'h003c,
                           16'h000a, 16'h0000, 16'h00c8, 16'h0000};

  tvc_core #(.TICK_DIV(TD), .INTEG_LIM(INTEG_LIM_DEF)) dut
  (
    .core_clk(core_clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data_reg(rd_data_reg), .temp_meas(temp_meas),
    .heat_valve_reg(heat_valve_reg), .cool_valve_reg(cool_valve_reg),
    .valve_pct_reg(valve_pct_reg), .cmd_send_reg(cmd_send_reg)
  );
  tvc_actuator act
  (
    .core_clk(core_clk), .srst(srst), .send(cmd_send_reg), .heat_cmd(heat_valve_reg),
    .cool_cmd(cool_valve_reg), .telegrams(telegrams), .heat_open(act_heat),
    .cool_open(act_cool)
  );

  // 10 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ========
  // Tasks
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge core_clk);
    wr_en   <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    chk("read data", rd_data_reg, exp);
  endtask

  task automatic vlv(input logic h, input logic c);
    @(negedge core_clk);
    chk("heat valve", {15'h0000, heat_valve_reg}, {15'h0000, h});
    chk("cool valve", {15'h0000, cool_valve_reg}, {15'h0000, c});
    chk("valve pct", {9'h000, valve_pct_reg}, (h | c) ? 16'h0064 : 16'h0000);
  endtask

  task automatic at_temp(input logic [15:0] t, input logic h, input logic c);
    @(posedge core_clk);
    temp_meas <= t;
    cyc(3);
    vlv(h, c);
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    srst <= 1'b1;
    cyc(8);
    srst <= 1'b0;
  endtask

  // One-minute cycle so a whole PWM period fits the run
  task automatic pwm(input logic [15:0] ctl, input logic [15:0] ti, input logic [15:0] t);
    wr(OFS_CYCLE_TIME, 16'h0001);
    temp_meas <= t;
    wr(OFS_INTEG_TIME, ti);
    wr(OFS_CTRL, ctl);
    cyc(2);
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ========
  // Tests
  initial
  begin
    srst      = 1'b1;
    addr      = 4'h0;
    wr_data   = 16'h0000;
    wr_en     = 1'b0;
    rd_en     = 1'b0;
    temp_meas = 16'h00c8;
    cyc(8);
    srst <= 1'b0;
    for (int i = 0; i < 10; i++)
      rd(ra[i], rv[i]);
    wr(OFS_STATUS, 16'hffff);
    rd(OFS_STATUS, 16'h0000);
    // Heating on/off with lockout after off-on-off
    wr(OFS_CTRL, 16'h0001);
    at_temp(16'h00c6, 1'b0, 1'b0);
    at_temp(16'h00c5, 1'b1, 1'b0);
    at_temp(16'h00c7, 1'b1, 1'b0);
    at_temp(16'h00c8, 1'b0, 1'b0);
    rd(OFS_STATUS, 16'h0004);
    at_temp(16'h00be, 1'b0, 1'b0);
    cyc(119 * TD);
    vlv(1'b0, 1'b0);
    cyc(2 * TD);
    vlv(1'b1, 1'b0);
    chk("telegrams", 16'(telegrams), 16'h0003);
    chk("actuator heat", {15'h0000, act_heat}, 16'h0001);
    // Percentage cooling with lockout after 0-100-0
    do_reset();
    wr(OFS_CTRL, 16'h0007);
    at_temp(16'h00ca, 1'b0, 1'b0);
    at_temp(16'h00cb, 1'b0, 1'b1);
    at_temp(16'h00c9, 1'b0, 1'b1);
    at_temp(16'h00c8, 1'b0, 1'b0);
    at_temp(16'h00d2, 1'b0, 1'b0);
    cyc(119 * TD);
    vlv(1'b0, 1'b0);
    cyc(2 * TD);
    vlv(1'b0, 1'b1);
    // PWM heating, proportional only: error 10 over band 20
    do_reset();
    pwm(16'h0009, 16'h0000, 16'h00be);
    rd(OFS_DUTY, 16'h0032);
    vlv(1'b1, 1'b0);
    cyc(27 * TD);
    vlv(1'b1, 1'b0);
    cyc(5 * TD);
    vlv(1'b0, 1'b0);
    wr(OFS_SETPOINT, 16'h00c9);
    cyc(2);
    vlv(1'b1, 1'b0);
    rd(OFS_DUTY, 16'h0037);
    pwm(16'h0009, 16'h0000, 16'h0096);
    rd(OFS_DUTY, 16'h0064);
    pwm(16'h0009, 16'h0000, 16'h00e6);
    rd(OFS_DUTY, 16'h0000);
    vlv(1'b0, 1'b0);
    // Integral part over two periods, two integration times
    for (int ti = 1; ti <= 2; ti++)
    begin
      do_reset();
      pwm(16'h0009, 16'(ti), 16'h00c4);
      rd(OFS_DUTY, 16'(20 + 20 / ti));
      cyc(60 * TD);
      rd(OFS_DUTY, 16'(20 + 40 / ti));
    end
    // PWM cooling
    do_reset();
    pwm(16'h000b, 16'h0000, 16'h00d2);
    rd(OFS_DUTY, 16'h0032);
    vlv(1'b0, 1'b1);
    wrap_up();
  end

  // Hang guard at about three times the expected run
  initial
  begin
    cyc(12000);
    fails++;
    wrap_up();
  end
endmodule

bind tvc_core tvc_core_chk #(.TICK_DIV(TICK_DIV), .INTEG_LIM(INTEG_LIM)) chk_i
(
  .core_clk(core_clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data_reg(rd_data_reg), .temp_meas(temp_meas),
  .heat_valve_reg(heat_valve_reg), .cool_valve_reg(cool_valve_reg),
  .valve_pct_reg(valve_pct_reg), .cmd_send_reg(cmd_send_reg)
);
